// [hw/sss_core.sv]
// Per-channel silence suppression and comfort noise state with an APB register file
//
// The APB register port and the address map were decided locally.
`include "sss_map.svh"

module sss_core
  import sss_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame decision from the voice activity detector
  input wire logic frame_valid,
  input wire logic frame_silent,
  input wire logic [7:0] frame_energy_db,
  // Underrun strobes per timeslot stream
  input wire logic [2:0] timeslot_stream_underrun,
  // Packet decisions
  output logic cn_send,
  output logic [7:0] cn_level,
  output logic voice_send,
  output logic voice_marker,
  output logic last_packet_suppressed_flag,
  output logic current_talk_flag
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] ctrl_ff;
  logic [31:0] period_ff;
  logic [7:0] latched_ff;
  logic [23:0] sum_ff;
  logic [7:0] ecnt_ff;
  logic [15:0] under_ff;
  logic new_cn_ff;
  sss_phase_t phase_ff;
  logic [31:0] tune0_ff;
  logic [31:0] tune1_ff;
  logic [31:0] tune2_ff;

  logic [2:0] cn_type;
  logic adj_sel;
  logic [7:0] thr;
  logic [7:0] first_per;
  logic [7:0] sub_per;
  logic [7:0] term;
  logic terminal;
  logic [7:0] avg_lvl;
  logic [7:0] diff;
  logic do_send;
  logic suppress;
  logic wr_en;
  logic rd_en;
  logic clr_sum_sw;
  logic clr_cnt_sw;
  logic [23:0] nxt_sum;
  logic partner_under;

  assign cn_type = ctrl_ff[`SSS_CTRL_TYPE_MSB:`SSS_CTRL_TYPE_LSB];
  assign adj_sel = ctrl_ff[`SSS_CTRL_ADJ_BIT];
  assign thr = ctrl_ff[`SSS_CTRL_THR_MSB:`SSS_CTRL_THR_LSB];
  assign first_per = period_ff[`SSS_PER_FIRST_MSB:`SSS_PER_FIRST_LSB];
  assign sub_per = period_ff[`SSS_PER_SUB_MSB:`SSS_PER_SUB_LSB];
  assign wr_en = clk_en && psel && penable && pwrite;
  assign rd_en = clk_en && psel && !penable && !pwrite;
  assign clr_sum_sw = wr_en && (paddr == `SSS_OFF_CLEAR) && pwdata[`SSS_CLR_SUM_BIT];
  assign clr_cnt_sw = wr_en && (paddr == `SSS_OFF_CLEAR) && pwdata[`SSS_CLR_CNT_BIT];

  // ----------------------------------------
  // Frame classification
  // ----------------------------------------
  // Types NONE, WHITE and PREPROG withhold silent frames; voice modes send everything
  assign suppress = frame_silent && ((cn_type == SSS_CN_NONE) || (cn_type == SSS_CN_WHITE) ||
                                     (cn_type == SSS_CN_PREPROG));
  assign term = (phase_ff == SSS_REFRESH) ? sub_per : first_per;
  assign terminal = frame_valid && frame_silent && ((ecnt_ff + `SSS_ONE8) >= term);
  assign nxt_sum = sum_ff + {16'h0000, frame_energy_db};

  // Average over the period; a zero period is treated as one frame
  always_comb begin
    if (term == `SSS_ZERO8) begin
      avg_lvl = frame_energy_db;
    end else begin
      avg_lvl = 8'(nxt_sum / {16'h0000, term});
    end
  end

  assign diff = (avg_lvl >= latched_ff) ? (avg_lvl - latched_ff) : (latched_ff - avg_lvl);

  // Only WHITE and PREPROG send: onset always, refresh needs the threshold, 128 and up block it, 01h or less passes any change
  always_comb begin
    if (cn_type != SSS_CN_WHITE && cn_type != SSS_CN_PREPROG) begin
      do_send = 1'b0;
    end else if (phase_ff != SSS_REFRESH) begin
      do_send = 1'b1;
    end else if (thr >= `SSS_THR_NEVER) begin
      do_send = 1'b0;
    end else if (thr <= `SSS_THR_ANY) begin
      do_send = (diff != `SSS_ZERO8);
    end else begin
      do_send = (diff >= thr);
    end
  end

  // ----------------------------------------
  // Phase tracking
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_ff <= SSS_TALK;
    end else if (clk_en && frame_valid) begin
      if (!frame_silent) begin
        phase_ff <= SSS_TALK;
      end else if (terminal) begin
        phase_ff <= SSS_REFRESH;
      end else if (phase_ff == SSS_TALK) begin
        phase_ff <= SSS_FIRST;
      end
    end
  end

  // ----------------------------------------
  // Energy counter and sum
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ecnt_ff <= `SSS_ZERO8;
    end else if (clk_en) begin
      if (frame_valid && !frame_silent) begin
        ecnt_ff <= `SSS_ZERO8;
      end else if (frame_valid && terminal) begin
        ecnt_ff <= `SSS_ZERO8;
      end else if (frame_valid) begin
        ecnt_ff <= ecnt_ff + `SSS_ONE8;
      end else if (clr_cnt_sw) begin
        ecnt_ff <= `SSS_ZERO8;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sum_ff <= `SSS_ZERO24;
    end else if (clk_en) begin
      if (frame_valid && (!frame_silent || terminal)) begin
        sum_ff <= `SSS_ZERO24;
      end else if (frame_valid) begin
        sum_ff <= nxt_sum;
      end else if (clr_sum_sw) begin
        sum_ff <= `SSS_ZERO24;
      end
    end
  end

  // ----------------------------------------
  // Comfort noise level and packet outputs
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      latched_ff <= `SSS_ZERO8;
      cn_level <= `SSS_ZERO8;
      cn_send <= 1'b0;
      new_cn_ff <= 1'b0;
    end else if (clk_en) begin
      cn_send <= 1'b0;
      if (terminal && do_send) begin
        latched_ff <= avg_lvl;
        cn_level <= avg_lvl;
        cn_send <= 1'b1;
        new_cn_ff <= 1'b1;
      end else if (rd_en && paddr == `SSS_OFF_STATUS) begin
        new_cn_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      voice_send <= 1'b0;
      voice_marker <= 1'b0;
      last_packet_suppressed_flag <= 1'b0;
      current_talk_flag <= 1'b1;
    end else if (clk_en) begin
      voice_send <= frame_valid && !suppress;
      voice_marker <= frame_valid && !frame_silent && !current_talk_flag &&
                      (cn_type == SSS_CN_VOICE_MARK_START || cn_type == SSS_CN_VOICE_MARK_ALL) ||
                      frame_valid && frame_silent && (cn_type == SSS_CN_VOICE_MARK_ALL);
      if (frame_valid) begin
        last_packet_suppressed_flag <= suppress;
        current_talk_flag <= !frame_silent;
      end
    end
  end

  // ----------------------------------------
  // Underrun counter on the partner stream
  // ----------------------------------------
  // Stream 0 is the suppressed one; its partner is 1 or 2
  assign partner_under = adj_sel ? timeslot_stream_underrun[2] : timeslot_stream_underrun[1];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      under_ff <= `SSS_ZERO16;
    end else if (clk_en && partner_under) begin
      under_ff <= under_ff + `SSS_ONE16;
    end
  end

  // ----------------------------------------
  // Context tuning words
  // ----------------------------------------
  // Held for the estimator software only; reserved bits read as zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tune0_ff <= `SSS_ZERO32;
      tune1_ff <= `SSS_ZERO32;
      tune2_ff <= `SSS_ZERO32;
    end else if (wr_en) begin
      if (paddr == `SSS_OFF_TUNE0) begin
        tune0_ff <= pwdata & `SSS_TUNE0_MASK;
      end
      if (paddr == `SSS_OFF_TUNE1) begin
        tune1_ff <= pwdata & `SSS_TUNE1_MASK;
      end
      if (paddr == `SSS_OFF_TUNE2) begin
        tune2_ff <= pwdata & `SSS_TUNE2_MASK;
      end
    end
  end

  // ----------------------------------------
  // APB register file
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_ff <= `SSS_RST_CTRL;
      period_ff <= `SSS_RST_PERIOD;
    end else if (wr_en) begin
      if (paddr == `SSS_OFF_CTRL) begin
        ctrl_ff <= pwdata;
      end
      if (paddr == `SSS_OFF_PERIOD) begin
        period_ff <= pwdata;
      end
    end
  end

  // Reads answer in the access cycle, zero wait states
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= `SSS_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `SSS_OFF_TUNE2 || paddr[1:0] != 2'b00);
      if (rd_en) begin
        unique case (paddr)
          `SSS_OFF_CTRL: prdata <= {16'h0000, thr, 4'h0, adj_sel, cn_type};
          `SSS_OFF_PERIOD: prdata <= {16'h0000, sub_per, first_per};
          `SSS_OFF_STATUS: prdata <= {29'h0000_0000, new_cn_ff, current_talk_flag,
                                      last_packet_suppressed_flag};
          `SSS_OFF_LATCHED: prdata <= {24'h00_0000, latched_ff};
          `SSS_OFF_SUM: prdata <= {8'h00, sum_ff};
          `SSS_OFF_COUNTS: prdata <= {under_ff, 8'h00, ecnt_ff};
          `SSS_OFF_TUNE0: prdata <= tune0_ff;
          `SSS_OFF_TUNE1: prdata <= tune1_ff;
          `SSS_OFF_TUNE2: prdata <= tune2_ff;
          default: prdata <= `SSS_ZERO32;
        endcase
      end
    end
  end

endmodule : sss_core

// [hw/sss_map.svh]
// Register offsets, field positions, reset values and encodings for the silence suppression state block
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH
// APB word offsets
`define SSS_OFF_CTRL 12'h000
`define SSS_OFF_PERIOD 12'h004
`define SSS_OFF_STATUS 12'h008
`define SSS_OFF_LATCHED 12'h00c
`define SSS_OFF_SUM 12'h010
`define SSS_OFF_COUNTS 12'h014
`define SSS_OFF_CLEAR 12'h018
`define SSS_OFF_TUNE0 12'h01c
`define SSS_OFF_TUNE1 12'h020
`define SSS_OFF_TUNE2 12'h024
// Tuning words: TUNE0 [3:0] rise, [7:4] fall, [15:8] hangover, [23:16] level ratio
// TUNE1 [15:0] upper decay, [31:16] lower decay; TUNE2 [7:0] upper start, [15:8] lower start
`define SSS_TUNE0_MASK 32'h00ff_ffff
`define SSS_TUNE1_MASK 32'hffff_ffff
`define SSS_TUNE2_MASK 32'h0000_ffff
// CTRL fields
`define SSS_CTRL_TYPE_LSB 0
`define SSS_CTRL_TYPE_MSB 2
`define SSS_CTRL_ADJ_BIT 3
`define SSS_CTRL_THR_LSB 8
`define SSS_CTRL_THR_MSB 15
// PERIOD fields
`define SSS_PER_FIRST_LSB 0
`define SSS_PER_FIRST_MSB 7
`define SSS_PER_SUB_LSB 8
`define SSS_PER_SUB_MSB 15
// STATUS fields
`define SSS_ST_LAST_SUPP_BIT 0
`define SSS_ST_TALK_BIT 1
`define SSS_ST_NEW_CN_BIT 2
// COUNTS fields
`define SSS_CNT_ENERGY_LSB 0
`define SSS_CNT_ENERGY_MSB 7
`define SSS_CNT_UNDER_LSB 16
`define SSS_CNT_UNDER_MSB 31
// CLEAR register bits
`define SSS_CLR_SUM_BIT 0
`define SSS_CLR_CNT_BIT 1
// Reset values
`define SSS_RST_CTRL 32'h0000_0100
`define SSS_RST_PERIOD 32'h0000_0808
// Threshold encodings
`define SSS_THR_ANY 8'h01
`define SSS_THR_NEVER 8'h80
// Misc constants
`define SSS_ONE8 8'h01
`define SSS_ONE16 16'h0001
`define SSS_ZERO8 8'h00
`define SSS_ZERO16 16'h0000
`define SSS_ZERO24 24'h00_0000
`define SSS_ZERO32 32'h0000_0000
`endif

// [hw/sss_pkg.sv]
// Types for the silence suppression state block
package sss_pkg;
  typedef enum logic [2:0] {
    SSS_CN_NONE = 3'h0,
    SSS_CN_WHITE = 3'h1,
    SSS_CN_PREPROG = 3'h2,
    SSS_CN_VOICE_MARK_START = 3'h3,
    SSS_CN_VOICE_MARK_ALL = 3'h4
  } sss_cn_type_t;
  typedef enum {SSS_TALK, SSS_FIRST, SSS_REFRESH} sss_phase_t;
endpackage : sss_pkg

// [dv/sss_core_sva.sv]
// Port assertions for the silence suppression state block
module sss_core_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Frames and decisions
  input wire logic frame_valid,
  input wire logic frame_silent,
  input wire logic cn_send,
  input wire logic [7:0] cn_level,
  input wire logic voice_send,
  input wire logic voice_marker,
  input wire logic last_packet_suppressed_flag,
  input wire logic current_talk_flag
);
  // ----------
  // Checks
  // ----------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("pready outside access");
  property p_zw; psel && !penable && clk_en |=> pready; endproperty
  a_zw: assert property (p_zw) else $error("no zero wait answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_talk;
    frame_valid && !frame_silent && clk_en |-> ##[1:2] (current_talk_flag && !last_packet_suppressed_flag);
  endproperty
  a_talk: assert property (p_talk) else $error("flags wrong after speech");
  property p_lvl; $changed(cn_level) |-> cn_send; endproperty
  a_lvl: assert property (p_lvl) else $error("level moved without packet");
  property p_pulse; cn_send && clk_en && !frame_valid |=> !cn_send; endproperty
  a_pulse: assert property (p_pulse) else $error("cn_send longer than a cycle");
  property p_cause; $rose(cn_send) |-> $past(frame_valid) && $past(clk_en); endproperty
  a_cause: assert property (p_cause) else $error("cn_send without frame");
  property p_mark; voice_marker |-> voice_send; endproperty
  a_mark: assert property (p_mark) else $error("marker without voice");
endmodule : sss_core_sva

// [dv/testbench.sv]
// Directed testbench for the silence suppression state block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, frame_valid = 0, frame_silent = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] frame_energy_db = 8'h00, cn_level;
  logic [2:0] tsu = 3'h0;
  logic pready, pslverr, cn_send, voice_send, voice_marker, lps, ctf, err;
  int n_mismatch = 0, checked = 0, cyc = 0;
  always #20 mclk = ~mclk;
  sss_core u_dut (.mclk, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .frame_valid, .frame_silent, .frame_energy_db, .timeslot_stream_underrun(tsu), .cn_send,
    .cn_level, .voice_send, .voice_marker, .last_packet_suppressed_flag(lps), .current_talk_flag(ctf));
  // ----------
  // Tasks
  // ----------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  // Packet pulses stand for exactly the one cycle after the taking edge
  task automatic frame(input logic s, input logic [7:0] e, input logic [2:0] exp);
    @(posedge mclk);
    frame_valid <= 1'b1;
    frame_silent <= s;
    frame_energy_db <= e;
    @(posedge mclk);
    frame_valid <= 1'b0;
    #1;
    chk({29'h0, cn_send, voice_send, voice_marker}, {29'h0, exp});
    @(posedge mclk);
    #1;
    chk({29'h0, cn_send, voice_send, voice_marker}, 32'h0);
  endtask : frame
  task automatic up(input logic [2:0] b);
    @(posedge mclk);
    tsu <= b;
    @(posedge mclk);
    tsu <= 3'h0;
  endtask : up
  // Hang guard, well above the fewer than two hundred cycles the sequence needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(12'h000, 32'h0000_0100);
    rdc(12'h004, 32'h0000_0808);
    rdc(12'h008, 32'h0000_0002);
    rdc(12'h01c, 32'h0);
    rdc(12'h028, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h018, 32'h0000_0003);
    apb(1'b1, 12'h01c, 32'h0008_1073);
    apb(1'b1, 12'h020, 32'h0a9c_012c);
    apb(1'b1, 12'h024, 32'hffff_1111);
    rdc(12'h01c, 32'h0008_1073);
    rdc(12'h020, 32'h0a9c_012c);
    rdc(12'h024, 32'h0000_1111);
    apb(1'b1, 12'h000, 32'h0000_0101);
    apb(1'b1, 12'h004, 32'h0000_0202);
    frame(1'b1, 8'h0a, 3'h0);
    chk({30'h0, ctf, lps}, 32'h1);
    rdc(12'h014, 32'h1);
    rdc(12'h010, 32'h0a);
    frame(1'b1, 8'h14, 3'h4);
    chk({24'h0, cn_level}, 32'h0f);
    rdc(12'h008, 32'h5);
    rdc(12'h008, 32'h1);
    rdc(12'h00c, 32'h0f);
    rdc(12'h010, 32'h0);
    frame(1'b1, 8'h0f, 3'h0);
    frame(1'b1, 8'h0f, 3'h0);
    frame(1'b1, 8'h11, 3'h0);
    frame(1'b1, 8'h13, 3'h4);
    rdc(12'h00c, 32'h12);
    apb(1'b1, 12'h000, 32'h0000_8001);
    frame(1'b1, 8'h28, 3'h0);
    frame(1'b1, 8'h28, 3'h0);
    rdc(12'h00c, 32'h12);
    apb(1'b1, 12'h000, 32'h0000_0201);
    frame(1'b1, 8'h14, 3'h0);
    frame(1'b1, 8'h14, 3'h4);
    frame(1'b1, 8'h15, 3'h0);
    frame(1'b1, 8'h15, 3'h0);
    frame(1'b1, 8'h05, 3'h0);
    frame(1'b0, 8'h32, 3'h2);
    chk({30'h0, ctf, lps}, 32'h2);
    rdc(12'h014, 32'h0);
    up(3'h2);
    up(3'h2);
    up(3'h4);
    apb(1'b1, 12'h000, 32'h0000_0209);
    up(3'h4);
    up(3'h2);
    up(3'h1);
    rdc(12'h014, 32'h0003_0000);
    apb(1'b1, 12'h000, 32'h0000_0104);
    frame(1'b1, 8'h05, 3'h3);
    apb(1'b1, 12'h000, 32'h0000_0101);
    apb(1'b1, 12'h004, 32'h0000_0301);
    frame(1'b0, 8'h20, 3'h2);
    frame(1'b1, 8'h0c, 3'h4);
    chk({24'h0, cn_level}, 32'h0c);
    frame(1'b1, 8'h0c, 3'h0);
    frame(1'b1, 8'h0c, 3'h0);
    frame(1'b1, 8'h0f, 3'h4);
    chk({24'h0, cn_level}, 32'h0d);
    frame(1'b1, 8'h0c, 3'h0);
    apb(1'b1, 12'h018, 32'h0000_0003);
    rdc(12'h010, 32'h0);
    rdc(12'h014, 32'h0003_0000);
    clk_en <= 1'b0;
    up(3'h2);
    clk_en <= 1'b1;
    rdc(12'h014, 32'h0003_0000);
    conclude();
  end
endmodule : testbench
bind sss_core sss_core_sva u_sva (.mclk, .rst_n, .clk_en, .psel, .penable, .pready, .pslverr, .frame_valid,
  .frame_silent, .cn_send, .cn_level, .voice_send, .voice_marker, .last_packet_suppressed_flag,
  .current_talk_flag);
